// ===== hdl/host_port_pkg.sv
package host_port_pkg;

  // =====================================================================
  // Bus geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int FIFO_SEL_BITS = 2;

  // =====================================================================
  // Address map (word addresses)
  localparam logic [ADDR_W-1:0] FIFO_WINDOW_TOP = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

  // =====================================================================
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic IRQ_PIN_RESET = 1'b0;

  // =====================================================================
  // Power state
  typedef enum logic {
    PWR_NORMAL = 1'b0,
    PWR_REDUCED = 1'b1
  } power_state_t;

endpackage

// ===== hdl/strobe_if.sv
`timescale 1ns/1ns
interface strobe_if;
  logic rd_level;
  logic wr_level;
  logic rd_start;
  logic wr_start;

  modport qual (
    output rd_level,
    output wr_level,
    output rd_start,
    output wr_start
  );

  modport port (
    input rd_level,
    input wr_level,
    input rd_start,
    input wr_start
  );
endinterface

// ===== hdl/strobe_qualifier.sv
`timescale 1ns/1ns
module strobe_qualifier (
  input wire logic clock,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  strobe_if.qual strobes
);

  logic rd_prev_r;
  logic wr_prev_r;

  // =====================================================================
  // Strobes count only while chip select is low
  assign strobes.rd_level = ~chip_select_n & ~read_strobe_n;
  assign strobes.wr_level = ~chip_select_n & ~write_strobe_n;
  assign strobes.rd_start = strobes.rd_level & ~rd_prev_r;
  assign strobes.wr_start = strobes.wr_level & ~wr_prev_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else begin
      rd_prev_r <= strobes.rd_level;
      wr_prev_r <= strobes.wr_level;
    end
  end

endmodule

// ===== hdl/host_bus_port.sv
`timescale 1ns/1ns
// Operation
// - The 7-bit word address picks a control_status_register or a FIFO.
// - A low read_strobe_n marks a read cycle.
// - A low write_strobe_n marks a write cycle.
// - Strobes are acted on only while chip_select_n is low.
// - In reduced power a chip-selected write wakes the device.
// - With fifo_select high every access goes to a FIFO, upper bits ignored.
// - One interrupt pin with programmable sources and driver; polarity in push-pull only, open drain is active low.
// - Only a chip-selected host write or reset ends reduced power, no other event.
// - The port acts as an asynchronous memory, at most one transfer per strobe; writes are dropped until a read after reset or wake.
module host_bus_port
  import host_port_pkg::*;
#(
  parameter int IRQ_SRC_W = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_n,
  input wire logic fifo_select,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] csr_read_data,
  input wire logic [DATA_W-1:0] fifo_read_data,
  output logic csr_read,
  output logic csr_write,
  output logic fifo_read,
  output logic fifo_write,
  output logic [ADDR_W-1:0] access_address,
  output logic [DATA_W-1:0] write_data,
  input wire logic sleep_request,
  output logic low_power,
  output logic wake_pulse,
  input wire logic [IRQ_SRC_W-1:0] irq_sources,
  input wire logic [IRQ_SRC_W-1:0] irq_enable,
  input wire logic irq_active_high,
  input wire logic irq_open_drain,
  output logic irq_out,
  output logic irq_oe
);

  strobe_if strobes();

  power_state_t power_r;
  logic read_seen_r;
  logic csr_read_r;
  logic csr_write_r;
  logic fifo_read_r;
  logic fifo_write_r;
  logic [ADDR_W-1:0] access_address_r;
  logic [DATA_W-1:0] write_data_r;
  logic [DATA_W-1:0] data_out_r;
  logic data_oe_r;
  logic wake_r;
  logic irq_out_r;
  logic irq_oe_r;
  logic read_fifo_r;
  logic to_fifo;
  logic awake;
  logic write_ok;
  logic irq_pending;
  logic [ADDR_W-1:0] decoded_address;

  strobe_qualifier u_strobe_qualifier (
    .clock(clock),
    .reset(reset),
    .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .strobes(strobes)
  );

  // =====================================================================
  // Address decode
  assign to_fifo = fifo_select | (address < FIFO_WINDOW_TOP);
  assign decoded_address = fifo_select ?
    {{(ADDR_W-FIFO_SEL_BITS){1'b0}}, address[FIFO_SEL_BITS-1:0]} :
    address;
  assign awake = (power_r == PWR_NORMAL);
  assign write_ok = awake & read_seen_r;

  // =====================================================================
  // Power state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      power_r <= PWR_NORMAL;
      wake_r <= 1'b0;
    end else begin
      wake_r <= 1'b0;
      case (power_r)
        PWR_NORMAL: begin
          if (sleep_request) begin
            power_r <= PWR_REDUCED;
          end
        end
        PWR_REDUCED: begin
          if (strobes.wr_start) begin
            power_r <= PWR_NORMAL;
            wake_r <= 1'b1;
          end
        end
        default: begin
          power_r <= PWR_NORMAL;
        end
      endcase
    end
  end

  // =====================================================================
  // First read after reset or wake enables writes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_seen_r <= 1'b0;
    end else if (!awake) begin
      read_seen_r <= 1'b0;
    end else if (strobes.rd_start) begin
      read_seen_r <= 1'b1;
    end
  end

  // =====================================================================
  // One request pulse per strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      csr_read_r <= 1'b0;
      csr_write_r <= 1'b0;
      fifo_read_r <= 1'b0;
      fifo_write_r <= 1'b0;
      access_address_r <= ADDR_ZERO;
      write_data_r <= DATA_RESET;
      read_fifo_r <= 1'b0;
    end else begin
      csr_read_r <= awake & strobes.rd_start & ~to_fifo;
      fifo_read_r <= awake & strobes.rd_start & to_fifo;
      csr_write_r <= write_ok & strobes.wr_start & ~to_fifo;
      fifo_write_r <= write_ok & strobes.wr_start & to_fifo;
      if (awake & (strobes.rd_start | strobes.wr_start)) begin
        access_address_r <= decoded_address;
      end
      if (awake & strobes.rd_start) begin
        read_fifo_r <= to_fifo;
      end
      if (write_ok & strobes.wr_start) begin
        write_data_r <= data_in;
      end
    end
  end

  // =====================================================================
  // Data bus drive
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      data_oe_r <= 1'b0;
      data_out_r <= DATA_RESET;
    end else begin
      data_oe_r <= strobes.rd_level & awake;
      data_out_r <= read_fifo_r ? fifo_read_data : csr_read_data;
    end
  end

  // =====================================================================
  // Interrupt pin
  assign irq_pending = |(irq_sources & irq_enable);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_out_r <= IRQ_PIN_RESET;
      irq_oe_r <= 1'b0;
    end else if (irq_open_drain) begin
      irq_out_r <= IRQ_PIN_RESET;
      irq_oe_r <= irq_pending;
    end else begin
      irq_out_r <= irq_pending ~^ irq_active_high;
      irq_oe_r <= 1'b1;
    end
  end

  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
  assign csr_read = csr_read_r;
  assign csr_write = csr_write_r;
  assign fifo_read = fifo_read_r;
  assign fifo_write = fifo_write_r;
  assign access_address = access_address_r;
  assign write_data = write_data_r;
  assign low_power = power_r;
  assign wake_pulse = wake_r;
  assign irq_out = irq_out_r;
  assign irq_oe = irq_oe_r;

  // =====================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_csr_read_decode: assert property (
    awake && strobes.rd_start && !fifo_select && address >= FIFO_WINDOW_TOP
    |=> csr_read && !fifo_read && access_address == $past(address))
    else $error("control register read not decoded");

  a_read_needs_strobe: assert property (
    (csr_read || fifo_read) |-> $past(~chip_select_n & ~read_strobe_n)
      && !$past(~chip_select_n & ~read_strobe_n, 2))
    else $error("read pulse without a new read strobe");

  a_write_needs_strobe: assert property (
    (csr_write || fifo_write) |-> $past(~chip_select_n & ~write_strobe_n)
      && $past(read_seen_r))
    else $error("write pulse without strobe or prior read");

  a_idle_no_cs: assert property (
    chip_select_n ##1 chip_select_n |=> !(csr_read || csr_write
      || fifo_read || fifo_write || data_oe) && !$rose(wake_pulse))
    else $error("activity while chip select high");

  a_write_wakes: assert property (
    power_r == PWR_REDUCED && strobes.wr_start
    |=> wake_pulse && !low_power && !csr_write && !fifo_write)
    else $error("chip-selected write did not wake");

  a_fifo_window: assert property (
    awake && fifo_select && (strobes.rd_start || strobes.wr_start)
    |=> !csr_read && !csr_write
      && access_address == {5'h00, $past(address[1:0])})
    else $error("fifo window access misrouted");

  a_irq_push_pull: assert property (
    !reset && !irq_open_drain ##1 1'b1 |-> irq_oe
      && irq_out == ($past(irq_pending) == $past(irq_active_high)))
    else $error("push-pull interrupt level wrong");

  a_irq_open_drain: assert property (
    !reset && irq_open_drain ##1 1'b1
    |-> !irq_out && irq_oe == $past(irq_pending))
    else $error("open-drain interrupt wrong");

  a_stay_asleep: assert property (
    power_r == PWR_REDUCED && !strobes.wr_start |=> power_r == PWR_REDUCED)
    else $error("left reduced power without a host write");

  a_one_pulse: assert property (
    csr_read || fifo_read |=> !csr_read && !fifo_read)
    else $error("read request longer than one cycle");

  a_bus_drive: assert property (
    data_oe |-> $past(~chip_select_n & ~read_strobe_n) && !$past(low_power))
    else $error("data bus driven outside a read");

  c_csr_read: cover property (csr_read ##[1:8] data_oe);
  c_fifo_write: cover property (fifo_write);
  c_wake: cover property (power_r == PWR_REDUCED ##1 wake_pulse);
  c_irq_od: cover property (irq_open_drain && irq_oe);

endmodule

// ===== tb/host_model.sv
`timescale 1ns/1ns
module host_model
  import host_port_pkg::*;
(
  input wire logic clock,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] address,
  output logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    address = 7'h00;
    data_in = 16'h0000;
  end
  // =====================================================================
  // One access: hold 4 cycles, sample the bus, release, idle
  task automatic xfer(input logic cs, rd, wr,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    output logic [DATA_W-1:0] q, output logic oe);
    @(posedge clock);
    chip_select_n <= cs;
    read_strobe_n <= rd;
    write_strobe_n <= wr;
    address <= a;
    data_in <= d;
    repeat (4) @(posedge clock);
    #1;
    q = data_out;
    oe = data_oe;
    @(posedge clock);
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    address <= ~a;
    // Released bus shows the inverse, not the last value
    data_in <= ~d;
    repeat (2) @(posedge clock);
    #1;
  endtask
endmodule

// ===== tb/test_sram_like_host_bus_port.sv
`timescale 1ns/1ns
module test_sram_like_host_bus_port;
  import host_port_pkg::*;
  logic clock, reset, fifo_select, sleep_request, ah, od, oe;
  logic cs_n, rd_n, wr_n, csr_read, csr_write, fifo_read, fifo_write;
  logic low_power, wake_pulse, irq_out, irq_oe, data_oe;
  logic [ADDR_W-1:0] address, access_address, a;
  logic [DATA_W-1:0] data_in, data_out, csr_rd, fifo_rd, write_data, d, q;
  logic [7:0] src, en;
  logic [4:0] pv;
  logic [31:0] seed;
  int cnt[5];
  int err_count, checks_done, cyc;
  assign pv = {csr_read, csr_write, fifo_read, fifo_write, wake_pulse};
  host_bus_port dut (.clock(clock), .reset(reset), .address(address),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chip_select_n(cs_n),
    .fifo_select(fifo_select), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .csr_read_data(csr_rd), .fifo_read_data(fifo_rd),
    .csr_read(csr_read), .csr_write(csr_write), .fifo_read(fifo_read),
    .fifo_write(fifo_write), .access_address(access_address),
    .write_data(write_data), .sleep_request(sleep_request),
    .low_power(low_power), .wake_pulse(wake_pulse), .irq_sources(src),
    .irq_enable(en), .irq_active_high(ah), .irq_open_drain(od),
    .irq_out(irq_out), .irq_oe(irq_oe));
  host_model host (.clock(clock), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .address(address),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    for (int k = 0; k < 5; k++)
      if (pv[k] === 1'b1) cnt[k]++;
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_irq(logic [7:0] s, e, logic h, o);
    logic p;
    p = |(s & e);
    return o ? {1'b0, p} : {p ~^ h, 1'b1};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================================================================
  // Access with expected request pulses {cr, cw, fr, fw, wake}
  task automatic run(input logic cs, rd, wr, input logic [6:0] a1,
    input logic [15:0] d1, input logic [4:0] pe);
    int b[5];
    logic [4:0] pg;
    b = cnt;
    host.xfer(cs, rd, wr, a1, d1, q, oe);
    for (int k = 0; k < 5; k++) pg[k] = (cnt[k] - b[k]) == 1;
    chk("request_pulses", 16'(pe), 16'(pg));
    chk("bus_drive", 16'(pe[4] | pe[2]), 16'(oe));
    chk("bus_released", 16'h0000, 16'(data_oe));
  endtask
  initial begin
    seed = 32'he585;
    reset = 1'b1;
    {fifo_select, sleep_request, ah, od, src, en} = '0;
    csr_rd = 16'h0000;
    fifo_rd = 16'h0000;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    csr_rd <= 16'(rnd());
    fifo_rd <= 16'(rnd());
    run(0, 1, 0, 7'h40, 16'h1234, 5'h00);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 7'h1f : (i == 1) ? FIFO_WINDOW_TOP : 7'(rnd());
      run(0, 0, 1, a, 16'h0000, a >= FIFO_WINDOW_TOP ? 5'h10 : 5'h04);
      chk("read_data", a >= FIFO_WINDOW_TOP ? csr_rd : fifo_rd, q);
      chk("read_address", 16'(a), 16'(access_address));
    end
    for (int i = 0; i < 6; i++) begin
      a = 7'(rnd());
      d = 16'(rnd());
      run(0, 1, 0, a, d, a >= FIFO_WINDOW_TOP ? 5'h08 : 5'h02);
      chk("write_data", d, write_data);
      chk("write_address", 16'(a), 16'(access_address));
    end
    fifo_select <= 1'b1;
    a = 7'(rnd()) | 7'h40;
    run(0, 1, 0, a, 16'h5a5a, 5'h02);
    chk("fifo_address", 16'(a[1:0]), 16'(access_address));
    run(0, 0, 1, a, 16'h0000, 5'h04);
    chk("fifo_data", fifo_rd, q);
    fifo_select <= 1'b0;
    run(1, 0, 1, 7'h40, 16'h0000, 5'h00);
    run(1, 1, 0, 7'h40, 16'h0000, 5'h00);
    @(posedge clock);
    sleep_request <= 1'b1;
    @(posedge clock);
    sleep_request <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("low_power", 16'h0001, 16'(low_power));
    run(0, 0, 1, 7'h40, 16'h0000, 5'h00);
    run(0, 1, 0, 7'h40, 16'h0000, 5'h01);
    chk("low_power", 16'h0000, 16'(low_power));
    run(0, 1, 0, 7'h41, 16'h0000, 5'h00);
    run(0, 0, 1, 7'h41, 16'h0000, 5'h10);
    run(0, 1, 0, 7'h41, 16'h00ff, 5'h08);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      src <= (i == 0) ? 8'h00 : 8'(rnd());
      en <= (i == 1) ? 8'hff : 8'(rnd());
      ah <= i[0];
      od <= i[1];
      repeat (2) @(posedge clock);
      #1;
      chk("irq_pin", 16'(exp_irq(src, en, ah, od)),
        16'({irq_out, irq_oe}));
    end
    tally_and_finish();
  end
endmodule
